// [hdl/timer_pkg.sv]
/*
  timer_pkg: register offsets, field positions, reset values and mode codes
  for the timer interface block. Assumes an 8-bit plain register port.
*/
package timer_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFF_STATUS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_MODULO_HIGH = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_MODULO_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CHAN0_CONTROL = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_CHAN0_HIGH = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_CHAN0_LOW = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_CHAN1_CONTROL = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CHAN1_HIGH = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_CHAN1_LOW = 4'ha;
  // status_control fields
  localparam int SC_OVF_FLAG = 7;
  localparam int SC_OVF_IRQ_EN = 6;
  localparam int SC_STOP = 5;
  localparam int SC_RESET = 4;
  localparam int SC_PS_LSB = 0;
  localparam logic [7:0] SC_RESET_VALUE = 8'h20;
  // channel control fields
  localparam int CH_FLAG = 7;
  localparam int CH_IRQ_EN = 6;
  localparam int CH_BUF_MODE = 5;
  localparam int CH_UNBUF_MODE = 4;
  localparam int CH_ELS_HI = 3;
  localparam int CH_ELS_LO = 2;
  localparam int CH_TOGGLE_OVF = 1;
  localparam int CH_MAX_DUTY = 0;
  localparam logic [7:0] CH_RESET_VALUE = 8'h00;
  localparam logic [15:0] MODULO_RESET = 16'hffff;
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [2:0] PS_UNUSED = 3'h7;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR = 2'b10,
    ACT_SET = 2'b11
  } edge_action_t;
endpackage : timer_pkg

// [hdl/timer_prescaler.sv]
/*
  timer_prescaler: divider, counting while run_i is high, making a one-cycle tick at bus clock / 2^sel.
  Assumes sel is stable and clear_i resets the divider chain.
*/
`timescale 1ns/1ps
module timer_prescaler (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic tick_o
);
  import timer_pkg::*;
  logic [6:0] div_r;
  logic [6:0] mask;

  always_comb begin
    mask = 7'((8'h01 << sel_i) - 8'h01);
  end

  // prescaler counts only while running, cleared with the counter
  always_ff @(posedge clock_i) begin
    if (rst_i || clear_i) begin
      div_r <= PRESCALE_RESET;
    end else if (run_i) begin
      div_r <= div_r + 7'h01;
    end
  end

  // code 111 gives no tick
  assign tick_o = run_i && !clear_i && (sel_i != PS_UNUSED) && ((div_r & mask) == mask);
endmodule : timer_prescaler

// [hdl/timer_channel.sv]
/*
  timer_channel: output compare / pwm output latch for one channel.
  Assumes match and overflow are one-cycle pulses from the counter.
*/
`timescale 1ns/1ps
module timer_channel (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic match_i,
  input wire logic overflow_i,
  input wire logic output_mode_i,
  input wire logic els_hi_i,
  input wire logic els_lo_i,
  input wire logic toggle_ovf_i,
  input wire logic max_duty_i,
  output logic level_o
);
  import timer_pkg::*;
  edge_action_t act;

  always_comb begin
    act = edge_action_t'({els_hi_i, els_lo_i});
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (output_mode_i) begin
      if (overflow_i && toggle_ovf_i && max_duty_i) begin
        level_o <= (act == ACT_CLEAR);
      end else if (overflow_i && toggle_ovf_i) begin
        level_o <= ~level_o;
      end else if (match_i && !max_duty_i) begin
        case (act)
          ACT_CLEAR: level_o <= 1'b0;
          ACT_SET: level_o <= 1'b1;
          ACT_TOGGLE: level_o <= ~level_o;
          default: level_o <= level_o;
        endcase
      end
    end
  end
endmodule : timer_channel

// [hdl/timer_interface_pwm.sv]
/*
  timer_interface_pwm: 16-bit prescaled up-counter with modulo, overflow flag,
  two output compare / pwm channels, buffered pwm link and input capture.
  Assumes a same-clock register master; capture pins are asynchronous.
*/
// Functional notes
// - overflow irq enable gates overflow flag onto irq; reset clears it.
// - stop bit holds counter; reset sets stop bit.
// - input captures suppressed while stop bit set.
// - counter reset bit clears counter and prescaler, self-clears, reads 0.
// - stop and reset together hold counter at zero.
// - prescale select divides bus clock by 2^code; 111 unused.
// - mode bits 0:1 unbuffered, 1:0 buffered compare or pwm.
// - edge bits 1:0 clear output on match, 1:1 set it.
// - toggle-on-overflow toggles output; clear gives 0% duty.
// - max duty with toggle-on-overflow gives 100% duty.
// - channel 0 buffered bit links channels, channel 0 first, wins over unbuffered.
// - buffered write to inactive channel takes effect at next period.
// - linked: channel 0 control drives output, channel 1 pin freed.
`timescale 1ns/1ps
module timer_interface_pwm (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [timer_pkg::ADDR_W-1:0] addr_i,
  input wire logic [timer_pkg::DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [1:0] capture_pin_i,
  output logic [timer_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  output logic chan0_pin_o,
  output logic chan0_pin_oe_o,
  output logic chan1_pin_o,
  output logic chan1_pin_oe_o
);
  import timer_pkg::*;

  logic [7:0] sc_r;
  logic [15:0] count_r;
  logic [15:0] modulo_r;
  logic [7:0] mod_high_latch_r;
  logic [7:0] ch_ctl_r [2];
  logic [15:0] ch_cmp_r [2];
  logic [7:0] ch_high_latch_r [2];
  logic active_r;
  logic pending_r;
  logic [1:0] cap_meta_r;
  logic [1:0] cap_sync_r;
  logic [1:0] cap_prev_r;
  logic tick;
  logic overflow;
  logic counter_reset;
  logic linked;
  logic [1:0] match;
  logic ch0_match;
  logic [1:0] out_mode;
  logic [1:0] capture;
  logic [1:0] level;
  logic ch_out_level;
  logic [7:0] rdata_nxt;

  function automatic logic is_write(input logic [ADDR_W-1:0] off);
    return write_i && (addr_i == off);
  endfunction : is_write

  function automatic logic is_output_mode(input logic [7:0] ctl);
    return ctl[CH_BUF_MODE] || ctl[CH_UNBUF_MODE];
  endfunction : is_output_mode

  assign counter_reset = is_write(OFF_STATUS_CONTROL) && wdata_i[SC_RESET];
  assign linked = ch_ctl_r[0][CH_BUF_MODE];

  timer_prescaler u_prescaler (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .clear_i(counter_reset),
    .run_i(!sc_r[SC_STOP]),
    .sel_i(sc_r[SC_PS_LSB +: 3]),
    .tick_o(tick)
  );

  assign overflow = tick && (count_r == modulo_r);
  assign ch0_match = linked ? match[active_r] : match[0];

  // status/control: flag set wins over software clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sc_r <= SC_RESET_VALUE;
    end else begin
      if (is_write(OFF_STATUS_CONTROL)) begin
        sc_r[SC_OVF_IRQ_EN] <= wdata_i[SC_OVF_IRQ_EN];
        sc_r[SC_STOP] <= wdata_i[SC_STOP];
        sc_r[SC_PS_LSB +: 3] <= wdata_i[SC_PS_LSB +: 3];
      end
      if (overflow) begin
        sc_r[SC_OVF_FLAG] <= 1'b1;
      end else if (is_write(OFF_STATUS_CONTROL) && !wdata_i[SC_OVF_FLAG]) begin
        sc_r[SC_OVF_FLAG] <= 1'b0;
      end
      sc_r[SC_RESET] <= 1'b0;
    end
  end

  // counter
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count_r <= COUNT_RESET;
    end else if (counter_reset) begin
      count_r <= COUNT_RESET;
    end else if (tick) begin
      count_r <= overflow ? COUNT_RESET : count_r + 16'h0001;
    end
  end

  // modulo with high byte latched until the low byte is written
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      modulo_r <= MODULO_RESET;
      mod_high_latch_r <= MODULO_RESET[15:8];
    end else if (is_write(OFF_MODULO_HIGH)) begin
      mod_high_latch_r <= wdata_i;
    end else if (is_write(OFF_MODULO_LOW)) begin
      modulo_r <= {mod_high_latch_r, wdata_i};
    end
  end

  // capture pins: two-flop synchroniser then edge detect
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cap_meta_r <= 2'b00;
      cap_sync_r <= 2'b00;
      cap_prev_r <= 2'b00;
    end else begin
      cap_meta_r <= capture_pin_i;
      cap_sync_r <= cap_meta_r;
      cap_prev_r <= cap_sync_r;
    end
  end

  // channels
  for (genvar c = 0; c < 2; c++) begin : g_chan
    assign out_mode[c] = (c == 0) ? is_output_mode(ch_ctl_r[0])
                                  : (!linked && is_output_mode(ch_ctl_r[1]));
    assign match[c] = tick && (count_r == ch_cmp_r[c]);
    assign capture[c] = !sc_r[SC_STOP] && !is_output_mode(ch_ctl_r[c])
        && (ch_ctl_r[c][CH_ELS_HI] || ch_ctl_r[c][CH_ELS_LO])
        && ((ch_ctl_r[c][CH_ELS_LO] && cap_sync_r[c] && !cap_prev_r[c])
         || (ch_ctl_r[c][CH_ELS_HI] && !cap_sync_r[c] && cap_prev_r[c]));

    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        ch_ctl_r[c] <= CH_RESET_VALUE;
      end else begin
        if (is_write(c ? OFF_CHAN1_CONTROL : OFF_CHAN0_CONTROL)) begin
          ch_ctl_r[c][6:0] <= wdata_i[6:0];
        end
        if ((out_mode[c] && ((c == 0) ? ch0_match : match[c])) || capture[c]) begin
          ch_ctl_r[c][CH_FLAG] <= 1'b1;
        end else if (is_write(c ? OFF_CHAN1_CONTROL : OFF_CHAN0_CONTROL)
                     && !wdata_i[CH_FLAG]) begin
          ch_ctl_r[c][CH_FLAG] <= 1'b0;
        end
      end
    end

    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        ch_cmp_r[c] <= COMPARE_RESET;
        ch_high_latch_r[c] <= COMPARE_RESET[15:8];
      end else if (capture[c]) begin
        ch_cmp_r[c] <= count_r;
      end else if (is_write(c ? OFF_CHAN1_HIGH : OFF_CHAN0_HIGH)) begin
        ch_high_latch_r[c] <= wdata_i;
      end else if (is_write(c ? OFF_CHAN1_LOW : OFF_CHAN0_LOW)) begin
        ch_cmp_r[c] <= {ch_high_latch_r[c], wdata_i};
      end
    end
  end

  // buffered pwm: active register pair switches at overflow to last written
  always_ff @(posedge clock_i) begin
    if (rst_i || !linked) begin
      active_r <= 1'b0;
      pending_r <= 1'b0;
    end else begin
      if (is_write(OFF_CHAN1_LOW)) begin
        pending_r <= 1'b1;
      end else if (is_write(OFF_CHAN0_LOW)) begin
        pending_r <= 1'b0;
      end
      if (overflow) begin
        active_r <= pending_r;
      end
    end
  end

  timer_channel u_chan0 (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .match_i(ch0_match),
    .overflow_i(overflow),
    .output_mode_i(out_mode[0]),
    .els_hi_i(ch_ctl_r[0][CH_ELS_HI]),
    .els_lo_i(ch_ctl_r[0][CH_ELS_LO]),
    .toggle_ovf_i(ch_ctl_r[0][CH_TOGGLE_OVF]),
    .max_duty_i(ch_ctl_r[0][CH_MAX_DUTY]),
    .level_o(level[0])
  );

  timer_channel u_chan1 (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .match_i(match[1]),
    .overflow_i(overflow),
    .output_mode_i(out_mode[1]),
    .els_hi_i(ch_ctl_r[1][CH_ELS_HI]),
    .els_lo_i(ch_ctl_r[1][CH_ELS_LO]),
    .toggle_ovf_i(ch_ctl_r[1][CH_TOGGLE_OVF]),
    .max_duty_i(ch_ctl_r[1][CH_MAX_DUTY]),
    .level_o(level[1])
  );

  assign ch_out_level = level[0];

  // pin outputs registered
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      chan0_pin_o <= 1'b0;
      chan0_pin_oe_o <= 1'b0;
      chan1_pin_o <= 1'b0;
      chan1_pin_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      chan0_pin_o <= ch_out_level;
      chan0_pin_oe_o <= out_mode[0];
      chan1_pin_o <= level[1];
      chan1_pin_oe_o <= out_mode[1];
      irq_o <= (sc_r[SC_OVF_FLAG] && sc_r[SC_OVF_IRQ_EN])
        || (ch_ctl_r[0][CH_FLAG] && ch_ctl_r[0][CH_IRQ_EN])
        || (!linked && ch_ctl_r[1][CH_FLAG] && ch_ctl_r[1][CH_IRQ_EN]);
    end
  end

  // read mux; reset bit always reads zero
  always_comb begin
    case (addr_i)
      OFF_STATUS_CONTROL: rdata_nxt = sc_r & ~(8'h01 << SC_RESET);
      OFF_COUNT_HIGH: rdata_nxt = count_r[15:8];
      OFF_COUNT_LOW: rdata_nxt = count_r[7:0];
      OFF_MODULO_HIGH: rdata_nxt = modulo_r[15:8];
      OFF_MODULO_LOW: rdata_nxt = modulo_r[7:0];
      OFF_CHAN0_CONTROL: rdata_nxt = ch_ctl_r[0];
      OFF_CHAN0_HIGH: rdata_nxt = ch_cmp_r[0][15:8];
      OFF_CHAN0_LOW: rdata_nxt = ch_cmp_r[0][7:0];
      OFF_CHAN1_CONTROL: rdata_nxt = ch_ctl_r[1];
      OFF_CHAN1_HIGH: rdata_nxt = ch_cmp_r[1][15:8];
      OFF_CHAN1_LOW: rdata_nxt = ch_cmp_r[1][7:0];
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (read_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  property p_stop_holds;
    @(posedge clock_i) disable iff (rst_i)
      (sc_r[SC_STOP] && !counter_reset) |=> $stable(count_r);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("counter moved while stopped");

  property p_reset_clears;
    @(posedge clock_i) disable iff (rst_i)
      counter_reset |=> (count_r == 16'h0000) && !sc_r[SC_RESET];
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("counter reset failed");

  property p_stop_and_reset;
    @(posedge clock_i) disable iff (rst_i)
      (counter_reset && wdata_i[SC_STOP]) |=> (count_r == 16'h0000) ##1 (count_r == 16'h0000);
  endproperty
  a_stop_and_reset: assert property (p_stop_and_reset) else $error("not held at zero");

  property p_irq_gate;
    @(posedge clock_i) disable iff (rst_i)
      (sc_r[SC_OVF_FLAG] && sc_r[SC_OVF_IRQ_EN]) |=> irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("overflow irq missing");

  property p_overflow_wrap;
    @(posedge clock_i) disable iff (rst_i)
      (overflow && !counter_reset) |=> (count_r == 16'h0000) && sc_r[SC_OVF_FLAG];
  endproperty
  a_overflow_wrap: assert property (p_overflow_wrap) else $error("overflow wrap wrong");

  property p_no_capture_stopped;
    @(posedge clock_i) disable iff (rst_i)
      (sc_r[SC_STOP] && !write_i) |=> $stable(ch_cmp_r[0]) && $stable(ch_cmp_r[1])
        && $stable(ch_ctl_r[0]) && $stable(ch_ctl_r[1]);
  endproperty
  a_no_capture_stopped: assert property (p_no_capture_stopped) else $error("capture while stopped");

  property p_ps_unused;
    @(posedge clock_i) disable iff (rst_i)
      (sc_r[SC_PS_LSB +: 3] == PS_UNUSED && !counter_reset) |=> $stable(count_r);
  endproperty
  a_ps_unused: assert property (p_ps_unused) else $error("tick on unused code");

  property p_chan1_freed;
    @(posedge clock_i) disable iff (rst_i)
      linked |=> !chan1_pin_oe_o;
  endproperty
  a_chan1_freed: assert property (p_chan1_freed) else $error("chan1 pin driven while linked");

  property p_buffer_switch;
    @(posedge clock_i) disable iff (rst_i)
      (linked && overflow && $past(linked)) |=> (active_r == $past(pending_r));
  endproperty
  a_buffer_switch: assert property (p_buffer_switch) else $error("buffer switch wrong");

  property p_full_duty;
    @(posedge clock_i) disable iff (rst_i)
      (out_mode[0] && overflow && ch_ctl_r[0][CH_MAX_DUTY] && ch_ctl_r[0][CH_TOGGLE_OVF]
       && ch_ctl_r[0][CH_ELS_HI] && !ch_ctl_r[0][CH_ELS_LO]) |=> level[0];
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not forced");

  property p_zero_duty;
    @(posedge clock_i) disable iff (rst_i)
      (out_mode[0] && !ch_ctl_r[0][CH_TOGGLE_OVF] && ch_ctl_r[0][CH_ELS_HI]
       && !ch_ctl_r[0][CH_ELS_LO] && !level[0]) |=> !level[0];
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("output left pulse off level");
endmodule : timer_interface_pwm

// [tb/tb.sv]
/*
  tb: self-checking bench for timer_interface_pwm, driving the register port,
  capture pins and watching irq and channel pins. Assumes timer_pkg offsets.
*/
`timescale 1ns/1ps
module tb;
  import timer_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic write_i = 1'b0;
  logic read_i = 1'b0;
  logic [1:0] capture_pin_i = 2'b00;
  logic [DATA_W-1:0] rdata_o;
  logic irq_o;
  logic chan0_pin_o;
  logic chan0_pin_oe_o;
  logic chan1_pin_o;
  logic chan1_pin_oe_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [7:0] d;
  logic [7:0] hi;
  int h;
  logic [7:0] ctl [4] = '{8'h1a, 8'h18, 8'h1b, 8'h1e};
  int duty [4] = '{16, 0, 40, 24};

  always #4 clock_i = ~clock_i;

  timer_interface_pwm i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .capture_pin_i(capture_pin_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .chan0_pin_o(chan0_pin_o),
    .chan0_pin_oe_o(chan0_pin_oe_o), .chan1_pin_o(chan1_pin_o),
    .chan1_pin_oe_o(chan1_pin_oe_o)
  );

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_near(input logic signed [31:0] got, input int exp, input int tol);
    chk({15'h0, (got >= exp - tol) && (got <= exp + tol)}, 16'h1);
  endtask : chk_near

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    write_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clock_i);
    write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_i);
    read_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task automatic measure(output int n, input logic pin1 = 1'b0);
    n = 0;
    repeat (40) begin
      @(posedge clock_i);
      #1 if ((pin1 ? chan1_pin_o : chan0_pin_o) === 1'b1) n++;
    end
  endtask : measure

  task automatic t_reset;
    rd(OFF_STATUS_CONTROL, d); chk(d, 16'h20);
    rd(OFF_CHAN0_CONTROL, d); chk(d, 16'h00);
    rd(OFF_MODULO_HIGH, d); chk(d, 16'hff);
    repeat (10) @(posedge clock_i);
    rd(OFF_COUNT_LOW, d); chk(d, 16'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_prescale;
    for (int ps = 0; ps < 7; ps++) begin
      wr(OFF_STATUS_CONTROL, 8'h30 | 8'(ps));
      wr(OFF_STATUS_CONTROL, 8'(ps));
      repeat (128) @(posedge clock_i);
      wr(OFF_STATUS_CONTROL, 8'h20 | 8'(ps));
      rd(OFF_COUNT_HIGH, hi);
      rd(OFF_COUNT_LOW, d);
      chk_near({hi, d}, 131 >> ps, 1);
      repeat (5) @(posedge clock_i);
      rd(OFF_COUNT_LOW, hi);
      chk(hi, d);
    end
    wr(OFF_STATUS_CONTROL, 8'h00);
    repeat (10) @(posedge clock_i);
    wr(OFF_STATUS_CONTROL, 8'h30);
    rd(OFF_COUNT_HIGH, d); chk(d, 16'h00);
    repeat (10) @(posedge clock_i);
    rd(OFF_COUNT_LOW, d); chk(d, 16'h00);
    rd(OFF_STATUS_CONTROL, d); chk(d, 16'h20);
    wr(OFF_STATUS_CONTROL, 8'h00);
    repeat (20) @(posedge clock_i);
    wr(OFF_STATUS_CONTROL, 8'h10);
    rd(OFF_COUNT_LOW, d); chk_near(d, 3, 3);
    rd(OFF_STATUS_CONTROL, d); chk(d, 16'h00);
    rd(OFF_MODULO_LOW, d); chk(d, 16'hff);
    $display("t_prescale done");
  endtask : t_prescale

  task automatic t_overflow;
    int i;
    wr(OFF_STATUS_CONTROL, 8'h30);
    wr(OFF_MODULO_HIGH, 8'h00);
    wr(OFF_MODULO_LOW, 8'h05);
    wr(OFF_STATUS_CONTROL, 8'h40);
    for (i = 0; i < 100 && irq_o !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    if (i == 100) begin
      n_mismatch++;
      $display("ERROR %0t: irq never raised", $time);
      end_of_test;
    end
    rd(OFF_STATUS_CONTROL, d); chk(d, 16'hc0);
    rd(OFF_COUNT_LOW, d); chk_near(d, 2, 3);
    wr(OFF_STATUS_CONTROL, 8'h00);
    repeat (2) @(posedge clock_i);
    repeat (20) begin
      @(posedge clock_i);
      #1 chk(irq_o, 16'h0);
    end
    $display("t_overflow done");
  endtask : t_overflow

  task automatic t_pwm;
    wr(OFF_STATUS_CONTROL, 8'h30);
    wr(OFF_MODULO_HIGH, 8'h00);
    wr(OFF_MODULO_LOW, 8'h09);
    wr(OFF_CHAN0_HIGH, 8'h00);
    wr(OFF_CHAN0_LOW, 8'h03);
    wr(OFF_CHAN0_CONTROL, 8'h1a);
    wr(OFF_STATUS_CONTROL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CHAN0_CONTROL, ctl[i]);
      repeat (20) @(posedge clock_i);
      measure(h);
      chk_near(h, duty[i], 1);
      chk(chan0_pin_oe_o, 16'h1);
    end
    $display("t_pwm done");
  endtask : t_pwm

  task automatic t_capture;
    wr(OFF_CHAN1_CONTROL, 8'h04);
    wr(OFF_STATUS_CONTROL, 8'h20);
    @(posedge clock_i);
    capture_pin_i <= 2'b10;
    repeat (8) @(posedge clock_i);
    rd(OFF_CHAN1_CONTROL, d); chk(d, 16'h04);
    @(posedge clock_i) capture_pin_i <= 2'b00;
    wr(OFF_STATUS_CONTROL, 8'h00);
    repeat (4) @(posedge clock_i);
    capture_pin_i <= 2'b10;
    repeat (8) @(posedge clock_i);
    rd(OFF_CHAN1_CONTROL, d); chk(d, 16'h84);
    @(posedge clock_i) capture_pin_i <= 2'b00;
    wr(OFF_CHAN1_CONTROL, 8'h00);
    $display("t_capture done");
  endtask : t_capture

  task automatic t_buffered;
    wr(OFF_STATUS_CONTROL, 8'h30);
    wr(OFF_CHAN0_CONTROL, 8'h2a);
    wr(OFF_CHAN0_HIGH, 8'h00);
    wr(OFF_CHAN0_LOW, 8'h03);
    wr(OFF_STATUS_CONTROL, 8'h00);
    repeat (20) @(posedge clock_i);
    measure(h); chk_near(h, 16, 1);
    chk(chan1_pin_oe_o, 16'h0);
    chk(chan0_pin_oe_o, 16'h1);
    wr(OFF_CHAN1_HIGH, 8'h00);
    wr(OFF_CHAN1_LOW, 8'h07);
    repeat (20) @(posedge clock_i);
    measure(h); chk_near(h, 32, 1);
    wr(OFF_CHAN0_HIGH, 8'h00);
    wr(OFF_CHAN0_LOW, 8'h01);
    repeat (20) @(posedge clock_i);
    measure(h); chk_near(h, 8, 1);
    wr(OFF_CHAN0_CONTROL, 8'h3a);
    wr(OFF_CHAN1_CONTROL, 8'h1a);
    repeat (20) @(posedge clock_i);
    measure(h); chk_near(h, 8, 1);
    chk(chan1_pin_oe_o, 16'h0);
    $display("t_buffered done");
  endtask : t_buffered

  task automatic t_chan1;
    wr(OFF_CHAN0_CONTROL, 8'h00);
    wr(OFF_CHAN1_HIGH, 8'h00);
    wr(OFF_CHAN1_LOW, 8'h05);
    wr(OFF_CHAN1_CONTROL, 8'h14);
    repeat (20) @(posedge clock_i);
    measure(h, 1'b1); chk_near(h, 20, 1);
    chk(chan1_pin_oe_o, 16'h1);
    rd(OFF_CHAN1_CONTROL, d); chk(d, 16'h94);
    wr(OFF_CHAN1_CONTROL, 8'h1a);
    repeat (20) @(posedge clock_i);
    measure(h, 1'b1); chk_near(h, 24, 1);
    wr(OFF_STATUS_CONTROL, 8'h07);
    rd(OFF_COUNT_LOW, d);
    repeat (5) @(posedge clock_i);
    rd(OFF_COUNT_LOW, hi); chk(hi, d);
    wr(OFF_STATUS_CONTROL, 8'h00);
    $display("t_chan1 done");
  endtask : t_chan1

  task automatic t_unmapped;
    wr(4'hb, 8'hff);
    rd(4'hb, d); chk(d, 16'h00);
    rd(4'hf, d); chk(d, 16'h00);
    $display("t_unmapped done");
  endtask : t_unmapped

  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    t_reset;
    t_prescale;
    t_overflow;
    t_pwm;
    t_capture;
    t_buffered;
    t_chan1;
    t_unmapped;
    end_of_test;
  end
endmodule : tb
